// ==== hdl/par_regs.v ====
// transceiver identification and auto-negotiation advertisement register bank
//
// Operation
// R1: The extended capability status bit is read-only and always reads as one.
// R2: Index two is a writable 16-bit register holding identifier bits three to eighteen.
// R3: Index three bits 15:10 are writable and hold identifier bits nineteen to twenty-four.
// R4: Index three bits 9:4 hold the six-bit model number.
// R5: Index three bits 3:0 hold a writable revision number whose reset value is a parameter.
// R6: Index four is a writable 16-bit advertisement register offered to the link partner.
// R7: Advertisement bit 15 is a writable next-page flag that resets to zero.
// R8: Advertisement bit 13 is a writable remote-fault flag that resets to zero.
// R9: Software should always write zero to the extended-next-page bit 12, which resets to zero.
// R10: Advertisement bit 11 is a writable asymmetric pause flag with a strap-derived reset.
// R11: Advertisement bit 10 is a writable symmetric pause flag with a strap-derived reset.
// R12: Advertisement bit 8 is a writable 100BASE-X full duplex flag resetting to one.
// R13: Advertisement bit 7 is a writable 100BASE-X half duplex flag resetting to one.
// R14: Advertisement bit 6 is a writable 10BASE-T full duplex flag with a strap-derived reset.
// R15: Pause bits reset to zero under manual flow control or fiber, else symmetric one and asymmetric from the strap.
// R16: The 10BASE-T full duplex reset is autoneg OR (NOT speed AND duplex), zero in fiber.
// R17: Writes to reserved bits 14 and 9 are ignored and they read as zero.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "par_regs_map.vh"

module par_regs #(
  parameter [15:0] OUI_UPPER_RST = 16'h1234,  // arbitrary value
  parameter [5:0]  OUI_LOWER_RST = 6'h2a,     // arbitrary value
  parameter [5:0]  MODEL_RST     = 6'h15,     // arbitrary value
  parameter [3:0]  REVISION_RST  = 4'h1,      // arbitrary value
  parameter [15:0] STATUS_OTHER  = 16'h0000
) (
  // clock and reset
  input  wire        CLK,
  input  wire        SRST,
  // register port
  input  wire [4:0]  ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [15:0] RDATA,
  // configuration straps, asynchronous pins
  input  wire        MANUAL_FLOW_CTRL_CFG_PIN_A,
  input  wire        FULL_DUPLEX_FLOW_CTRL_CFG_PIN_A,
  input  wire        AUTONEG_CFG_PIN,
  input  wire        SPEED_CFG_PIN,
  input  wire        DUPLEX_CFG_PIN,
  input  wire        FIBER_MODE_PIN,
  // advertised abilities toward negotiation logic
  output wire [15:0] ADV_ABILITIES
);

  reg  [5:0]  sync1_ff;
  reg  [5:0]  sync2_ff;
  reg         load_ff;
  reg  [15:0] oui_upper_identifier_ff;
  reg  [5:0]  oui_lower_ff;
  reg  [5:0]  model_ff;
  reg  [3:0]  revision_ff;
  reg         next_page_ff;
  reg         rem_fault_ff;
  reg         ext_next_page_ff;
  reg         asym_pause_ff;
  reg         sym_pause_ff;
  reg         fd100_ff;
  reg         hd100_ff;
  reg         fd10_ff;
  reg         hd10_ff;
  reg  [4:0]  selector_ff;
  reg  [15:0] oui_lower_model_revision;
  reg  [15:0] autoneg_advertised_abilities;
  reg  [15:0] rd_mux;
  wire        wr_oui_upper;
  wire        wr_oui_lower;
  wire        wr_adv;
  wire        manual_fc;
  wire        fd_fc;
  wire        an_strap;
  wire        speed_strap;
  wire        duplex_strap;
  wire        fiber;
  wire        strap_sym;
  wire        strap_asym;
  wire        strap_10fd;
  wire        strap_10hd;

  // strap synchroniser
  always @(posedge CLK) begin
    sync1_ff <= {MANUAL_FLOW_CTRL_CFG_PIN_A, FULL_DUPLEX_FLOW_CTRL_CFG_PIN_A,
                 AUTONEG_CFG_PIN, SPEED_CFG_PIN, DUPLEX_CFG_PIN, FIBER_MODE_PIN};
    sync2_ff <= sync1_ff;
  end

  assign manual_fc    = sync2_ff[5];
  assign fd_fc        = sync2_ff[4];
  assign an_strap     = sync2_ff[3];
  assign speed_strap  = sync2_ff[2];
  assign duplex_strap = sync2_ff[1];
  assign fiber        = sync2_ff[0];

  // R15: pause strap defaults
  assign strap_sym  = ~fiber & ~manual_fc;
  assign strap_asym = ~fiber & ~manual_fc & fd_fc;
  // R16: 10 full duplex default
  assign strap_10fd = ~fiber & (an_strap | (~speed_strap & duplex_strap));
  assign strap_10hd = ~fiber & (an_strap | ~speed_strap);

  // strap-derived values are loaded on the cycle after reset release,
  // once the synchroniser holds settled pin levels
  always @(posedge CLK) begin
    if (SRST) begin
      load_ff <= 1'b1;
    end else begin
      load_ff <= 1'b0;
    end
  end

  // register port write decodes
  assign wr_oui_upper = WR & (ADDR == `PAR_IDX_OUI_UPPER);
  assign wr_oui_lower = WR & (ADDR == `PAR_IDX_OUI_LOWER);
  assign wr_adv       = WR & (ADDR == `PAR_IDX_ADV);

  // R2: upper identifier write
  always @(posedge CLK) begin
    if (SRST) begin
      oui_upper_identifier_ff <= OUI_UPPER_RST;
    end else if (wr_oui_upper) begin
      oui_upper_identifier_ff <= WDATA;
    end
  end

  // R3: lower identifier write
  always @(posedge CLK) begin
    if (SRST) begin
      oui_lower_ff <= OUI_LOWER_RST;
    end else if (wr_oui_lower) begin
      oui_lower_ff <= WDATA[`PAR_ID_OUI_HI:`PAR_ID_OUI_LO];
    end
  end

  // R4: model number field
  always @(posedge CLK) begin
    if (SRST) begin
      model_ff <= MODEL_RST;
    end else if (wr_oui_lower) begin
      model_ff <= WDATA[`PAR_ID_MODEL_HI:`PAR_ID_MODEL_LO];
    end
  end

  // R5: revision number field
  always @(posedge CLK) begin
    if (SRST) begin
      revision_ff <= REVISION_RST;
    end else if (wr_oui_lower) begin
      revision_ff <= WDATA[`PAR_ID_REV_HI:`PAR_ID_REV_LO];
    end
  end

  // lower identifier word as software sees it
  always @* begin
    oui_lower_model_revision                                    = 16'h0000;
    oui_lower_model_revision[`PAR_ID_OUI_HI:`PAR_ID_OUI_LO]     = oui_lower_ff;
    oui_lower_model_revision[`PAR_ID_MODEL_HI:`PAR_ID_MODEL_LO] = model_ff;
    oui_lower_model_revision[`PAR_ID_REV_HI:`PAR_ID_REV_LO]     = revision_ff;
  end

  // R7: next page flag
  always @(posedge CLK) begin
    if (SRST) begin
      next_page_ff <= `PAR_ADV_NEXT_PAGE_RST;
    end else if (wr_adv) begin
      next_page_ff <= WDATA[`PAR_ADV_NEXT_PAGE];
    end
  end

  // R8: remote fault flag
  always @(posedge CLK) begin
    if (SRST) begin
      rem_fault_ff <= `PAR_ADV_REM_FAULT_RST;
    end else if (wr_adv) begin
      rem_fault_ff <= WDATA[`PAR_ADV_REM_FAULT];
    end
  end

  // R9: extended next page storage
  always @(posedge CLK) begin
    if (SRST) begin
      ext_next_page_ff <= `PAR_ADV_EXT_NP_RST;
    end else if (wr_adv) begin
      ext_next_page_ff <= WDATA[`PAR_ADV_EXT_NP];
    end
  end

  // R12: 100 full duplex
  always @(posedge CLK) begin
    if (SRST) begin
      fd100_ff <= `PAR_ADV_100_FD_RST;
    end else if (wr_adv) begin
      fd100_ff <= WDATA[`PAR_ADV_100_FD];
    end
  end

  // R13: 100 half duplex
  always @(posedge CLK) begin
    if (SRST) begin
      hd100_ff <= `PAR_ADV_100_HD_RST;
    end else if (wr_adv) begin
      hd100_ff <= WDATA[`PAR_ADV_100_HD];
    end
  end

  // selector field
  always @(posedge CLK) begin
    if (SRST) begin
      selector_ff <= `PAR_ADV_SELECTOR_RST;
    end else if (wr_adv) begin
      selector_ff <= WDATA[`PAR_ADV_SEL_HI:`PAR_ADV_SEL_LO];
    end
  end

  // R10: asymmetric pause, write beats strap load
  always @(posedge CLK) begin
    if (SRST) begin
      asym_pause_ff <= `PAR_ADV_STRAP_RST;
    end else if (wr_adv) begin
      asym_pause_ff <= WDATA[`PAR_ADV_ASYM_PAUSE];
    end else if (load_ff) begin
      asym_pause_ff <= strap_asym;
    end
  end

  // R11: symmetric pause flag
  always @(posedge CLK) begin
    if (SRST) begin
      sym_pause_ff <= `PAR_ADV_STRAP_RST;
    end else if (wr_adv) begin
      sym_pause_ff <= WDATA[`PAR_ADV_SYM_PAUSE];
    end else if (load_ff) begin
      sym_pause_ff <= strap_sym;
    end
  end

  // R14: 10 full duplex
  always @(posedge CLK) begin
    if (SRST) begin
      fd10_ff <= `PAR_ADV_STRAP_RST;
    end else if (wr_adv) begin
      fd10_ff <= WDATA[`PAR_ADV_10_FD];
    end else if (load_ff) begin
      fd10_ff <= strap_10fd;
    end
  end

  // 10 half duplex, strap default
  always @(posedge CLK) begin
    if (SRST) begin
      hd10_ff <= `PAR_ADV_STRAP_RST;
    end else if (wr_adv) begin
      hd10_ff <= WDATA[`PAR_ADV_10_HD];
    end else if (load_ff) begin
      hd10_ff <= strap_10hd;
    end
  end

  // R6: advertisement word assembly
  // R17: reserved bits stay zero
  always @* begin
    autoneg_advertised_abilities                      = 16'h0000;
    autoneg_advertised_abilities[`PAR_ADV_NEXT_PAGE]  = next_page_ff;
    autoneg_advertised_abilities[`PAR_ADV_REM_FAULT]  = rem_fault_ff;
    autoneg_advertised_abilities[`PAR_ADV_EXT_NP]     = ext_next_page_ff;
    autoneg_advertised_abilities[`PAR_ADV_ASYM_PAUSE] = asym_pause_ff;
    autoneg_advertised_abilities[`PAR_ADV_SYM_PAUSE]  = sym_pause_ff;
    autoneg_advertised_abilities[`PAR_ADV_100_FD]     = fd100_ff;
    autoneg_advertised_abilities[`PAR_ADV_100_HD]     = hd100_ff;
    autoneg_advertised_abilities[`PAR_ADV_10_FD]      = fd10_ff;
    autoneg_advertised_abilities[`PAR_ADV_10_HD]      = hd10_ff;
    autoneg_advertised_abilities[`PAR_ADV_SEL_HI:`PAR_ADV_SEL_LO] = selector_ff;
  end

  always @* begin
    case (ADDR)
      // R1: extended capability one
      `PAR_IDX_STATUS: begin
        rd_mux                    = STATUS_OTHER;
        rd_mux[`PAR_STAT_EXT_CAP] = 1'b1;
      end
      `PAR_IDX_OUI_UPPER: rd_mux = oui_upper_identifier_ff;
      `PAR_IDX_OUI_LOWER: rd_mux = oui_lower_model_revision;
      `PAR_IDX_ADV:       rd_mux = autoneg_advertised_abilities;
      default:            rd_mux = 16'h0000;
    endcase
  end

  always @(posedge CLK) begin
    if (SRST) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      RDATA <= rd_mux;
    end else begin
      RDATA <= 16'h0000;
    end
  end

  assign ADV_ABILITIES = autoneg_advertised_abilities;

endmodule // par_regs

`default_nettype wire

// ==== pkg/par_regs_map.vh ====
// register map constants for the transceiver id and advertisement bank
`ifndef PAR_REGS_MAP_VH
`define PAR_REGS_MAP_VH
`define PAR_IDX_STATUS      5'h01
`define PAR_IDX_OUI_UPPER   5'h02
`define PAR_IDX_OUI_LOWER   5'h03
`define PAR_IDX_ADV         5'h04
`define PAR_STAT_EXT_CAP    0
`define PAR_ADV_NEXT_PAGE   15
`define PAR_ADV_RSVD_HI     14
`define PAR_ADV_REM_FAULT   13
`define PAR_ADV_EXT_NP      12
`define PAR_ADV_ASYM_PAUSE  11
`define PAR_ADV_SYM_PAUSE   10
`define PAR_ADV_RSVD_LO     9
`define PAR_ADV_100_FD      8
`define PAR_ADV_100_HD      7
`define PAR_ADV_10_FD       6
`define PAR_ADV_10_HD       5
`define PAR_ADV_SEL_HI      4
`define PAR_ADV_WR_MASK     16'hbdff
`define PAR_ADV_SELECTOR_RST 5'h01
`define PAR_ADV_SEL_LO      0
`define PAR_ID_OUI_HI       15
`define PAR_ID_OUI_LO       10
`define PAR_ID_MODEL_HI     9
`define PAR_ID_MODEL_LO     4
`define PAR_ID_REV_HI       3
`define PAR_ID_REV_LO       0
`define PAR_ADV_NEXT_PAGE_RST 1'b0
`define PAR_ADV_REM_FAULT_RST 1'b0
`define PAR_ADV_EXT_NP_RST    1'b0
`define PAR_ADV_100_FD_RST    1'b1
`define PAR_ADV_100_HD_RST    1'b1
`define PAR_ADV_STRAP_RST     1'b0
`endif

// ==== tb/par_host.sv ====
// host model on the register port
`timescale 1ns/1ps
`default_nettype none
module par_host (
  input  wire logic        clk,
  output var  logic [4:0]  addr = 5'h00,
  output var  logic [15:0] wdata = 16'h0000,
  output var  logic        wr = 1'b0,
  output var  logic        rd = 1'b0,
  input  wire logic [15:0] rdata
);
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    // extended next page written as zero
    wdata <= (a == 5'h04) ? (d & 16'hefff) : d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~wdata;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask
endmodule // par_host
`default_nettype wire

// ==== tb/par_regs_chk.sv ====
// assertions on the id and advertisement bank ports
`timescale 1ns/1ps
`default_nettype none
module par_chk (
  // clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // register port
  input wire logic [4:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  // straps
  input wire logic        MANUAL_FLOW_CTRL_CFG_PIN_A,
  input wire logic        FULL_DUPLEX_FLOW_CTRL_CFG_PIN_A,
  input wire logic        AUTONEG_CFG_PIN,
  input wire logic        SPEED_CFG_PIN,
  input wire logic        DUPLEX_CFG_PIN,
  input wire logic        FIBER_MODE_PIN,
  // advertised abilities
  input wire logic [15:0] ADV_ABILITIES
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  AST_EXT: assert property (RD && ADDR == 5'h01 |=> RDATA[0]) else $error("ext bit low");
  AST_RSV: assert property (!ADV_ABILITIES[14] && !ADV_ABILITIES[9]) else $error("rsvd set");
  AST_WADV: assert property (WR && ADDR == 5'h04 |=> ADV_ABILITIES == ($past(WDATA) & 16'hbdff))
    else $error("adv write");
  AST_RADV: assert property (RD && ADDR == 5'h04 |=> RDATA == $past(ADV_ABILITIES)) else $error("adv read");
  AST_HOLD: assert property (!$past(SRST) && !(WR && ADDR == 5'h04) |=> $stable(ADV_ABILITIES))
    else $error("adv moved");
  AST_RSTV: assert property ($fell(SRST) |-> ADV_ABILITIES == 16'h0181) else $error("adv reset");
  AST_PAUSE: assert property ($fell(SRST) && !WR |=> ADV_ABILITIES[11:10] ==
    {!MANUAL_FLOW_CTRL_CFG_PIN_A && FULL_DUPLEX_FLOW_CTRL_CFG_PIN_A && !FIBER_MODE_PIN,
     !MANUAL_FLOW_CTRL_CFG_PIN_A && !FIBER_MODE_PIN}) else $error("pause reset");
  AST_TFD: assert property ($fell(SRST) && !WR |=> ADV_ABILITIES[6] ==
    ((AUTONEG_CFG_PIN || !SPEED_CFG_PIN && DUPLEX_CFG_PIN) && !FIBER_MODE_PIN)) else $error("10fd reset");
endmodule // par_chk
bind par_regs par_chk u_chk (.CLK(CLK), .SRST(SRST), .WR(WR), .RD(RD), .ADDR(ADDR), .WDATA(WDATA),
  .RDATA(RDATA), .ADV_ABILITIES(ADV_ABILITIES), .MANUAL_FLOW_CTRL_CFG_PIN_A(MANUAL_FLOW_CTRL_CFG_PIN_A),
  .FULL_DUPLEX_FLOW_CTRL_CFG_PIN_A(FULL_DUPLEX_FLOW_CTRL_CFG_PIN_A), .AUTONEG_CFG_PIN(AUTONEG_CFG_PIN),
  .SPEED_CFG_PIN(SPEED_CFG_PIN), .DUPLEX_CFG_PIN(DUPLEX_CFG_PIN), .FIBER_MODE_PIN(FIBER_MODE_PIN));
`default_nettype wire

// ==== tb/tb_par_regs.sv ====
// self-checking bench for the id and advertisement bank
`timescale 1ns/1ps
`default_nettype none
module tb_par_regs;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  strap = 6'h00;
  logic [15:0] rdata, wdata, adv, q, d;
  logic [4:0]  addr;
  logic        wr, rd;
  int          errors = 0, checked = 0, cyc = 0;
  logic [31:0] seed = 32'h6a225d46;
  always #12.5 clk = ~clk;
  par_host u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  par_regs u_dut (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .MANUAL_FLOW_CTRL_CFG_PIN_A(strap[5]), .FULL_DUPLEX_FLOW_CTRL_CFG_PIN_A(strap[4]), .AUTONEG_CFG_PIN(strap[3]),
    .SPEED_CFG_PIN(strap[2]), .DUPLEX_CFG_PIN(strap[1]), .FIBER_MODE_PIN(strap[0]), .ADV_ABILITIES(adv));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [15:0] exp_adv(input logic [5:0] s);
    exp_adv = 16'h0181;
    exp_adv[11] = !s[5] && s[4] && !s[0];
    exp_adv[10] = !s[5] && !s[0];
    exp_adv[6] = (s[3] || !s[2] && s[1]) && !s[0];
    exp_adv[5] = (s[3] || !s[2]) && !s[0];
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task summarize;
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize;
    end
  end
  initial begin
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      srst  <= 1'b1;
      strap <= (i == 0) ? 6'h00 : 6'(rnd());
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      u_host.rd_reg(5'h04, q);
      chk(q, exp_adv(strap));
      chk(adv, exp_adv(strap));
      d = 16'(rnd());
      u_host.wr_reg(5'h04, d);
      u_host.rd_reg(5'h04, q);
      chk(q, d & 16'hadff);
      chk(adv, d & 16'hadff);
      u_host.wr_reg(5'h02, d);
      u_host.wr_reg(5'h03, ~d);
      u_host.rd_reg(5'h02, q);
      chk(q, d);
      u_host.rd_reg(5'h03, q);
      chk(q, ~d);
      u_host.wr_reg(5'h01, ~d);
      u_host.rd_reg(5'h01, q);
      chk(q, 16'h0001);
      u_host.rd_reg(5'h1f, q);
      chk(q, 16'h0000);
      @(negedge clk);
      chk(rdata, 16'h0000);
    end
    summarize;
  end
endmodule // tb_par_regs
`default_nettype wire
